//--- hdl/hbe_buf2.sv
// Two-entry buffer in the path toward the USB chip
`timescale 1ns/1ps
`default_nettype none
module hbe_buf2
    import hbe_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   nrst,
    hbe_stream_if.snk   in_s,
    hbe_stream_if.src   out_s
);
    hbe_word_t  ent [2];
    logic       rd_ptr;
    logic       wr_ptr;
    logic [1:0] count;
    logic       push;
    logic       pop;

    // Honest full and empty from the occupancy count
    assign in_s.ready  = (count != 2'h2);
    assign out_s.valid = (count != 2'h0);
    assign out_s.word  = ent[rd_ptr];
    assign push        = in_s.valid & in_s.ready;
    assign pop         = out_s.valid & out_s.ready;

    // Entry storage, written only on an accepted push
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ent[0] <= '0;
            ent[1] <= '0;
        end else if (push) begin
            ent[wr_ptr] <= in_s.word;
        end
    end

    // Pointers and count; push and pop may share a cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop) begin
                count <= count + 2'h1;
            end else if (pop && !push) begin
                count <= count - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- hdl/hbe_byte_tx.sv
// Single-byte send logic: one strobe per rising send request
`timescale 1ns/1ps
`default_nettype none
`include "hbe_map.svh"
module hbe_byte_tx
    import hbe_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      nrst,
    input  wire logic      enable,
    input  wire logic      start_req,
    input  wire hbe_byte_t host_bound_byte,
    output logic           strobe,
    output hbe_byte_t      byte_q,
    output logic           in_prog
);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            byte_q  <= `HBE_BYTE_RST;
            strobe  <= 1'b0;
            in_prog <= 1'b0;
        end else if (start_req && !in_prog && enable) begin
            byte_q  <= host_bound_byte;
            strobe  <= 1'b1;
            in_prog <= 1'b1;
        end else if (start_req && in_prog) begin
            strobe  <= 1'b0;
        end else if (!start_req) begin
            strobe  <= 1'b0;
            in_prog <= 1'b0;
        end else begin
            strobe  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- hdl/hbe_top.sv
// Host byte and block endpoint with APB control and buffered USB path
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "hbe_map.svh"
module hbe_top
    import hbe_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // User side, byte endpoint
    input  wire logic                 start_transfer,
    input  wire hbe_byte_t            host_bound_byte,
    output logic                      byte_received,
    output hbe_byte_t                 device_bound_byte,
    // User side, block endpoint
    input  wire logic                 block_start,
    input  wire hbe_addr_t            endpoint_address_in,
    input  wire logic [`HBE_LEN_W-1:0] block_length_in,
    input  wire hbe_byte_t            block_host_byte,
    output logic                      block_byte_ready,
    output logic                      block_received,
    output logic                      block_busy,
    output hbe_byte_t                 block_device_byte,
    // USB chip side, outbound
    output logic                      usb_tx_valid,
    input  wire logic                 usb_tx_ready,
    output logic                      usb_tx_block,
    output hbe_addr_t                 usb_tx_addr,
    output hbe_byte_t                 usb_tx_data,
    // USB chip side, inbound
    input  wire logic                 usb_rx_valid,
    output logic                      usb_rx_ready,
    input  wire logic                 usb_rx_block,
    input  wire hbe_addr_t            usb_rx_addr,
    input  wire hbe_byte_t            usb_rx_data,
    input  wire logic                 usb_rx_last
);
    // Control register state
    hbe_addr_t                 byte_addr;
    logic                      enable;
    logic [15:0]               blocks_done;

    // Byte endpoint state
    logic                      byte_strobe;
    hbe_byte_t                 byte_q;
    logic                      byte_in_prog;
    logic                      byte_pend;
    hbe_word_t                 pend_word;

    // Block send state
    logic                      block_start_q;
    logic                      start_flag;
    logic                      tx_ready_q;
    logic [`HBE_LEN_W-1:0]     blk_count;
    logic                      start_rise;
    logic                      tx_slot;
    logic                      count_done;

    // Block receive state
    logic                      rx_pend;
    logic                      rx_last_q;
    logic                      rx_ready_q;
    hbe_byte_t                 rx_hold;
    logic                      rx_take;

    // APB decode
    logic                      apb_setup;
    logic                      apb_wr;
    logic                      addr_ok;

    hbe_stream_if buf_in ();
    hbe_stream_if buf_out ();

    hbe_byte_tx u_byte_tx (
        .clk             (clk),
        .nrst            (nrst),
        // A word still waiting for the buffer blocks a new take but keeps
        // the request level, so a held request cannot rearm itself
        .enable          (enable & ~byte_pend),
        .start_req       (start_transfer),
        .host_bound_byte (host_bound_byte),
        .strobe          (byte_strobe),
        .byte_q          (byte_q),
        .in_prog         (byte_in_prog)
    );

    hbe_buf2 u_buf (
        .clk   (clk),
        .nrst  (nrst),
        .in_s  (buf_in),
        .out_s (buf_out)
    );

    // Buffer output straight to the USB chip; its ready stalls the buffer
    assign usb_tx_valid  = buf_out.valid;
    assign usb_tx_block  = buf_out.word.blk;
    assign usb_tx_addr   = buf_out.word.addr;
    assign usb_tx_data   = buf_out.word.data;
    assign buf_out.ready = usb_tx_ready;

    // block byte goes out on the ready pulse
    // Block words win; a pending single byte waits for a free cycle
    assign buf_in.valid = tx_ready_q | byte_pend;
    always_comb begin
        if (tx_ready_q) begin
            buf_in.word = '{blk: 1'b1, addr: endpoint_address_in, data: block_host_byte};
        end else begin
            buf_in.word = pend_word;
        end
    end

    // byte word tagged with its own endpoint address
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            byte_pend <= 1'b0;
            pend_word <= '0;
        end else if (byte_strobe) begin
            byte_pend <= 1'b1;
            pend_word <= '{blk: 1'b0, addr: byte_addr, data: byte_q};
        end else if (byte_pend && !tx_ready_q && buf_in.ready) begin
            byte_pend <= 1'b0;
        end
    end

    // Edge detect on the block start input
    assign start_rise = block_start & ~block_start_q;
    assign count_done = (blk_count >= block_length_in);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            block_start_q <= 1'b0;
        end else begin
            block_start_q <= block_start;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            start_flag <= 1'b0;
            block_busy <= 1'b0;
        end else if (start_rise && !start_flag && enable) begin
            start_flag <= 1'b1;
        end else if (start_flag && !block_busy) begin
            block_busy <= 1'b1;
        end else if (count_done) begin
            start_flag <= 1'b0;
            block_busy <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blk_count <= '0;
        end else if (tx_ready_q) begin
            blk_count <= blk_count + `HBE_LEN_W'(1);
        end else if (count_done) begin
            blk_count <= '0;
        end
    end

    // pulses stop at length
    // A slot needs buffer room now, so the pushed word is never lost;
    // the low cycle between pulses gives the user time to change its byte
    assign tx_slot = block_busy & ~tx_ready_q & ~byte_pend & buf_in.ready &
                     (blk_count < block_length_in);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_ready_q <= 1'b0;
        end else begin
            tx_ready_q <= tx_slot;
        end
    end

    // Completed block sends, readable by software
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blocks_done <= 16'h0000;
        end else if (block_busy && count_done && !start_flag) begin
            blocks_done <= blocks_done;
        end else if (block_busy && count_done) begin
            blocks_done <= blocks_done + 16'h0001;
        end
    end

    // Inbound stream: one word in flight; block words wait while sending
    assign usb_rx_ready = ~rx_pend & ~rx_ready_q & ~(usb_rx_block & block_busy);
    assign rx_take      = usb_rx_valid & usb_rx_ready & enable;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            byte_received     <= 1'b0;
            device_bound_byte <= `HBE_BYTE_RST;
        end else if (rx_take && !usb_rx_block && usb_rx_addr == byte_addr) begin
            byte_received     <= 1'b1;
            device_bound_byte <= usb_rx_data;
        end else begin
            byte_received     <= 1'b0;
        end
    end

    // received flag leads each pulse
    // Flag rises with the first word, pulse follows one clock later
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_pend           <= 1'b0;
            rx_last_q         <= 1'b0;
            rx_hold           <= `HBE_BYTE_RST;
            rx_ready_q        <= 1'b0;
            block_received    <= 1'b0;
            block_device_byte <= `HBE_BYTE_RST;
        end else begin
            rx_ready_q <= 1'b0;
            if (rx_take && usb_rx_block && usb_rx_addr == endpoint_address_in) begin
                rx_pend        <= 1'b1;
                rx_last_q      <= usb_rx_last;
                rx_hold        <= usb_rx_data;
                block_received <= 1'b1;
            end else if (rx_pend) begin
                rx_pend           <= 1'b0;
                rx_ready_q        <= 1'b1;
                block_device_byte <= rx_hold;
            end else if (rx_ready_q && rx_last_q) begin
                block_received <= 1'b0;
            end
        end
    end

    // Send and receive pulses overlap only for an rx block word taken the cycle before busy rises
    assign block_byte_ready = tx_ready_q | rx_ready_q;

    // APB: zero wait states, read data registered in the setup cycle
    assign pready    = 1'b1;
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pwrite;
    assign addr_ok   = (paddr == `HBE_OFS_CTRL) || (paddr == `HBE_OFS_STATUS) ||
                       (paddr == `HBE_OFS_BLOCKS);

    // Control register write; steers the byte endpoint address and the enable of both endpoints
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            byte_addr <= hbe_addr_t'(`HBE_CTRL_RST);
            enable    <= 1'b1;
        end else if (apb_wr && paddr == `HBE_OFS_CTRL) begin
            byte_addr <= pwdata[`HBE_CTRL_ADDR_MSB:`HBE_CTRL_ADDR_LSB];
            enable    <= pwdata[`HBE_CTRL_EN_BIT];
        end
    end

    // Read mux and error flag, captured in the setup cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            pslverr <= ~addr_ok;
            prdata  <= 32'h0000_0000;
            case (paddr)
                `HBE_OFS_CTRL: begin
                    prdata[`HBE_CTRL_ADDR_MSB:`HBE_CTRL_ADDR_LSB] <= byte_addr;
                    prdata[`HBE_CTRL_EN_BIT]                      <= enable;
                end
                `HBE_OFS_STATUS: begin
                    prdata[`HBE_ST_BYTE_BUSY]                          <= byte_in_prog;
                    prdata[`HBE_ST_BLK_BUSY]                           <= block_busy;
                    prdata[`HBE_ST_BLK_RX]                             <= block_received;
                    prdata[`HBE_ST_BYTE_PEND]                          <= byte_pend;
                    prdata[`HBE_ST_CNT_LSB+`HBE_LEN_W-1:`HBE_ST_CNT_LSB] <= blk_count;
                end
                `HBE_OFS_BLOCKS: begin
                    prdata[15:0] <= blocks_done;
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- pkg/hbe_map.svh
// Constants for the host byte and block endpoint: offsets, fields, resets
// Functional notes
// - Byte from host on the device-bound output raises byte_received one clock.
// - Each endpoint carries its own address; up to eight can coexist.
// - Each block byte-ready pulse passes block_host_byte toward the USB chip.
// - Block send continues one byte per pulse until length bytes are sent.
// - While block_received is high, each byte-ready pulse outside a block send marks a valid byte.
// - All transfers are sequenced by the single system clock.
// - Byte-send logic resets asynchronously on low reset, else rising edges.
// - First request cycle latches byte and strobes once; low request rearms. A byte still pending for the buffer delays the latch to a later request cycle.
// - Reset clears latched byte, send strobe and in-progress flag.
// - Rising block start sets start flag and busy; both clear at count.
// - Block counter counts byte-ready cycles, returns to zero at length.
// - No further byte while start stays high; needs a low clock first.
`ifndef HBE_MAP_SVH
`define HBE_MAP_SVH

// Register byte offsets
`define HBE_OFS_CTRL      8'h00
`define HBE_OFS_STATUS    8'h04
`define HBE_OFS_BLOCKS    8'h08

// Control register fields
`define HBE_CTRL_ADDR_LSB 0
`define HBE_CTRL_ADDR_MSB 2
`define HBE_CTRL_EN_BIT   3
`define HBE_CTRL_RST      4'h8

// Status register fields
`define HBE_ST_BYTE_BUSY  0
`define HBE_ST_BLK_BUSY   1
`define HBE_ST_BLK_RX     2
`define HBE_ST_BYTE_PEND  3
`define HBE_ST_CNT_LSB    16

// Widths and reset values
`define HBE_LEN_W         16
`define HBE_BYTE_RST      8'h00

`endif

//--- pkg/hbe_pkg.sv
// Types shared by the host byte and block endpoint
package hbe_pkg;
    typedef logic [2:0] hbe_addr_t;
    typedef logic [7:0] hbe_byte_t;
    // One outbound word toward the USB chip
    typedef struct packed {
        logic      blk;
        hbe_addr_t addr;
        hbe_byte_t data;
    } hbe_word_t;
endpackage

//--- pkg/hbe_stream_if.sv
// Valid/ready word stream between the endpoint and its buffer
`timescale 1ns/1ps
`default_nettype none
interface hbe_stream_if;
    import hbe_pkg::*;
    logic      valid;
    logic      ready;
    hbe_word_t word;
    modport src (output valid, output word, input ready);
    modport snk (input valid, input word, output ready);
endinterface
`default_nettype wire

//--- tb/hbe_top_assertions.sv
// Port-level checker for the endpoint top
`timescale 1ns/1ps
`default_nettype none
`include "hbe_map.svh"
module hbe_chk
    import hbe_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  nrst,
    input wire logic                  pready,
    input wire logic                  byte_received,
    input wire logic                  block_start,
    input wire logic [`HBE_LEN_W-1:0] block_length_in,
    input wire logic                  block_byte_ready,
    input wire logic                  block_received,
    input wire logic                  block_busy,
    input wire logic                  usb_tx_valid,
    input wire logic                  usb_tx_ready,
    input wire logic                  usb_tx_block,
    input wire hbe_addr_t             usb_tx_addr,
    input wire hbe_byte_t             usb_tx_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [`HBE_LEN_W-1:0] sent_cnt;
    // Pulses of the current send, cleared when idle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sent_cnt <= '0;
        end else if (block_busy && block_byte_ready) begin
            sent_cnt <= sent_cnt + 1'b1;
        end else if (!block_busy) begin
            sent_cnt <= '0;
        end
    end
    sequence blk_go_s;
        $rose(block_start) && !block_busy;
    endsequence
    sequence rx_open_s;
        $rose(block_received);
    endsequence
    zero_wait_a: assert property (pready) else $error("pready low");
    byte_pulse_a: assert property (byte_received |=> !byte_received)
        else $error("byte pulse too long");
    ready_pulse_a: assert property (block_byte_ready |=> !block_byte_ready)
        else $error("ready pulse too long");
    start_busy_a: assert property (blk_go_s |-> ##2 block_busy)
        else $error("busy not raised");
    busy_end_a: assert property ($fell(block_busy) |-> sent_cnt == block_length_in)
        else $error("send count wrong");
    tx_hold_a: assert property (usb_tx_valid && !usb_tx_ready |=> usb_tx_valid
        && $stable({usb_tx_block, usb_tx_addr, usb_tx_data})) else $error("word lost");
    rx_mark_a: assert property (block_byte_ready && !block_busy |-> block_received)
        else $error("stray ready");
    rx_first_a: assert property (rx_open_s |=> block_byte_ready)
        else $error("first byte late");
endmodule
`default_nettype wire

//--- tb/hbe_usb_model.sv
// Behavioural bridge chip: stalling sink and inbound word source
`timescale 1ns/1ps
`default_nettype none
module hbe_usb_model
    import hbe_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      nrst,
    input  wire logic      slow,
    input  wire logic      usb_tx_valid,
    output logic           usb_tx_ready,
    input  wire logic      usb_tx_block,
    input  wire hbe_addr_t usb_tx_addr,
    input  wire hbe_byte_t usb_tx_data,
    output logic           usb_rx_valid,
    input  wire logic      usb_rx_ready,
    output logic           usb_rx_block,
    output hbe_addr_t      usb_rx_addr,
    output hbe_byte_t      usb_rx_data,
    output logic           usb_rx_last
);
    hbe_word_t  txq[$];
    logic [2:0] phase;
    initial begin
        {usb_rx_valid, usb_rx_block, usb_rx_addr, usb_rx_data, usb_rx_last} = '0;
        usb_tx_ready = 1'b1;
    end
    // one clock domain
    // Slow mode refuses four of every eight cycles so the buffer fills
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            usb_tx_ready <= 1'b1;
            phase <= 3'h0;
        end else begin
            if (usb_tx_valid === 1'b1 && usb_tx_ready)
                txq.push_back({usb_tx_block, usb_tx_addr, usb_tx_data});
            phase <= phase + 3'h1;
            usb_tx_ready <= !(slow && phase[2]);
        end
    end
    task automatic send(input logic b, input hbe_addr_t a, input hbe_byte_t d, input logic l);
        int n;
        @(posedge clk);
        {usb_rx_valid, usb_rx_block, usb_rx_addr, usb_rx_data, usb_rx_last} <= {1'b1, b, a, d, l};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (usb_rx_ready !== 1'b1 && n < 64);
        // A word never taken is a mismatch for the closing report
        if (usb_rx_ready !== 1'b1) tb_top.fails++;
        // Released lines show the inverse so no stale value passes
        {usb_rx_valid, usb_rx_block, usb_rx_addr, usb_rx_data, usb_rx_last} <= {1'b0, ~b, ~a, ~d, ~l};
    endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the endpoint top
`timescale 1ns/1ps
`default_nettype none
`include "hbe_map.svh"
module tb_top;
    import hbe_pkg::*;
    logic                  clk, nrst, psel, penable, pwrite, pready, pslverr, err, slow;
    logic [7:0]            paddr;
    logic [31:0]           pwdata, prdata, rd, seed;
    logic                  start_transfer, byte_received, block_start, block_byte_ready;
    logic                  block_received, block_busy, usb_tx_valid, usb_tx_ready, usb_tx_block;
    logic                  usb_rx_valid, usb_rx_ready, usb_rx_block, usb_rx_last;
    hbe_byte_t             host_bound_byte, device_bound_byte, block_host_byte;
    hbe_byte_t             block_device_byte, usb_tx_data, usb_rx_data, hb;
    hbe_addr_t             endpoint_address_in, usb_tx_addr, usb_rx_addr;
    logic [`HBE_LEN_W-1:0] block_length_in;
    int                    fails, total_checks, idx, n;
    hbe_byte_t             blk_buf [0:3];
    hbe_byte_t             rxq[$], brq[$];
    hbe_top dut_u (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .start_transfer, .host_bound_byte, .byte_received, .device_bound_byte,
        .block_start, .endpoint_address_in, .block_length_in, .block_host_byte,
        .block_byte_ready, .block_received, .block_busy, .block_device_byte, .usb_tx_valid,
        .usb_tx_ready, .usb_tx_block, .usb_tx_addr, .usb_tx_data, .usb_rx_valid,
        .usb_rx_ready, .usb_rx_block, .usb_rx_addr, .usb_rx_data, .usb_rx_last);
    hbe_usb_model usb_u (.clk, .nrst, .slow, .usb_tx_valid, .usb_tx_ready, .usb_tx_block,
        .usb_tx_addr, .usb_tx_data, .usb_rx_valid, .usb_rx_ready, .usb_rx_block,
        .usb_rx_addr, .usb_rx_data, .usb_rx_last);
    assign block_host_byte = blk_buf[idx[1:0]];
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (block_byte_ready === 1'b1 && block_busy === 1'b1) idx <= idx + 1;
        if (block_byte_ready === 1'b1 && block_received === 1'b1) rxq.push_back(block_device_byte);
        if (byte_received === 1'b1) brq.push_back(device_bound_byte);
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic summarize();
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One cycle of a bounded wait
    task automatic step();
        @(posedge clk);
        n++;
        if (n > 400) begin
            fails++;
            summarize();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do step(); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, start_transfer, host_bound_byte} = '0;
        {block_start, endpoint_address_in, block_length_in, slow, idx, fails} = '0;
        total_checks = 0;
        seed = 32'h00003C06;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        // Reset values, read-only status, unmapped place
        for (int i = 0; i < 8; i++) begin
            if (i == 4) apb(1'b1, `HBE_OFS_STATUS, 32'hFFFFFFFF);
            if (i == 4) apb(1'b1, 8'h0C, 32'hFFFFFFFF);
            apb(1'b0, 8'(4 * (i % 4)), 32'h0);
            chk(rd, (i % 4 == 0) ? {28'h0, `HBE_CTRL_RST} : 32'h0);
            chk({31'h0, err}, (i % 4 == 3) ? 32'h1 : 32'h0);
        end
        apb(1'b1, `HBE_OFS_CTRL, 32'h0000000D);
        apb(1'b0, `HBE_OFS_CTRL, 32'h0);
        chk(rd, 32'h0000000D);
        // Byte send: held request sends once, a low cycle rearms
        for (int i = 0; i < 2; i++) begin
            hb = 8'(rnd());
            host_bound_byte <= hb;
            start_transfer <= 1'b1;
            n = 0;
            while (usb_u.txq.size() < 1) step();
            host_bound_byte <= ~hb;
            repeat (8) @(posedge clk);
            chk(usb_u.txq.size(), 32'h1);
            chk({20'h0, usb_u.txq.pop_front()}, {20'h0, 1'b0, 3'h5, hb});
            start_transfer <= 1'b0;
            @(posedge clk);
        end
        // Byte receive, foreign address dropped
        hb = 8'(rnd());
        usb_u.send(1'b0, 3'h3, ~hb, 1'b0);
        usb_u.send(1'b0, 3'h5, hb, 1'b0);
        repeat (4) @(posedge clk);
        chk(brq.size(), 32'h1);
        chk(brq[0], hb);
        for (int i = 0; i < 4; i++) blk_buf[i] = 8'(rnd());
        {slow, endpoint_address_in, block_length_in} <= {1'b1, 3'h4, 16'h0003};
        @(posedge clk);
        block_start <= 1'b1;
        n = 0;
        while (block_busy !== 1'b1) step();
        block_start <= 1'b0;
        @(posedge clk);
        block_start <= 1'b1;
        while (block_busy !== 1'b0 || usb_u.txq.size() < 3) step();
        repeat (10) @(posedge clk);
        chk(usb_u.txq.size(), 32'h3);
        for (int i = 0; i < 3; i++) chk(usb_u.txq[i], {1'b1, 3'h4, blk_buf[i]});
        block_start <= 1'b0;
        slow <= 1'b0;
        apb(1'b0, `HBE_OFS_BLOCKS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, `HBE_OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        // Block receive, foreign block word dropped
        for (int i = 0; i < 4; i++) blk_buf[i] = 8'(rnd());
        usb_u.send(1'b1, 3'h2, 8'h5A, 1'b0);
        for (int i = 0; i < 3; i++) usb_u.send(1'b1, 3'h4, blk_buf[i], i == 2);
        n = 0;
        while (rxq.size() < 3 || block_received !== 1'b0) step();
        for (int i = 0; i < 3; i++) chk(rxq[i], blk_buf[i]);
        // Endpoints switched off: a matching byte is consumed but not delivered
        apb(1'b1, `HBE_OFS_CTRL, 32'h00000005);
        usb_u.send(1'b0, 3'h5, 8'hA5, 1'b0);
        repeat (4) @(posedge clk);
        chk(brq.size(), 32'h1);
        apb(1'b0, `HBE_OFS_CTRL, 32'h0);
        chk(rd, 32'h00000005);
        summarize();
    end
endmodule
bind hbe_top hbe_chk chk_u (.clk, .nrst, .pready, .byte_received, .block_start,
    .block_length_in, .block_byte_ready, .block_received, .block_busy, .usb_tx_valid,
    .usb_tx_ready, .usb_tx_block, .usb_tx_addr, .usb_tx_data);
`default_nettype wire
